// [src/pso_defs.svh]
`ifndef PSO_DEFS_SVH
`define PSO_DEFS_SVH

// Register byte addresses (APB, one word each)
`define PSO_ADDR_CTRL 12'h000
`define PSO_ADDR_STAT 12'h004
`define PSO_ADDR_NVM 12'h008
`define PSO_ADDR_CLKMASK 12'h00C

// CTRL fields
`define PSO_CTRL_BACKUP_IRQ_ENABLE 0
`define PSO_CTRL_POWER_LOSS_IRQ_ENABLE 1
// NVM image fields
`define PSO_NVM_MODE_LO 0
`define PSO_NVM_MODE_HI 1
`define PSO_NVM_TCM_LO 2
`define PSO_NVM_TCM_HI 3
`define PSO_NVM_TCR_LO 4
`define PSO_NVM_TCR_HI 5
`define PSO_NVM_W 6
// STAT fields
`define PSO_STAT_POWER_LOSS_FLAG 0
`define PSO_STAT_BSF 1
`define PSO_STAT_VLF 2
`define PSO_STAT_BACKUP 3
`define PSO_STAT_REFRESH 4
`define PSO_STAT_CLKF 5
`define PSO_STAT_ARMED 6
`define PSO_STAT_DEB 7

// Reset values
`define PSO_CTRL_RST 2'h0
`define PSO_NVM_RST 6'h00
`define PSO_MASK_RST 8'h00

// Timing, in microseconds, and the clock period in ns
`define PSO_CLK_NS 10
`define PSO_REFR_US 66000
`define PSO_DEB_SHORT_US 1000
`define PSO_DEB_LONG_US 1000000
`define PSO_ARM_DSM_US 2000
`define PSO_ARM_LSM_US 10000
// All times round down to whole cycles
`define PSO_US2CYC(us) (((us) * 1000) / `PSO_CLK_NS)

`endif

// [src/pso_pkg.sv]
package pso_pkg;

  typedef enum logic [1:0] {
    PSO_MODE_OFF0 = 2'h0,
    PSO_MODE_DIRECT = 2'h1,
    PSO_MODE_LEVEL = 2'h2,
    PSO_MODE_OFF3 = 2'h3
  } pso_mode_t;

  typedef enum logic [3:0] {
    PSO_ST_REFRESH = 4'h1,
    PSO_ST_MAIN = 4'h2,
    PSO_ST_BACKUP = 4'h4,
    PSO_ST_DEBOUNCE = 4'h8
  } pso_state_t;

endpackage

// [src/pso_power_ctl.sv]
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "pso_defs.svh"

// How it works
// - Reset loads every register, mirrors to defaults
// - Copy nonvolatile image into mirrors after power-up
// - Power-loss flag set on reset, cleared by 0-write
// - Power-loss interrupt armed by reset; asserts once the enable, cleared by reset, is written
// - Power-loss interrupt regardless of prior flag clearing
// - Debounce host port 1 or 1000 ms
// - Mode 00/11 off, 01 direct, 10 level
// - Direct: backup when main below backup
// - Level: threshold rules, else direct
// - Backup entry sets switched-to-backup flag
// - Backup enable drives interrupt until flag cleared
// - Backup resets and floats host port
// - Backup disables external event detection
// - Backup forces clock output low
// - Temperature functions keep running in backup
// - Masked interrupt in backup enables clock output later
// - Switchover disabled keeps backup flag zero
// - First power-up on backup: switchover off
// - Switchover effective within 2 or 10 ms
// - Charger off: mode 00, switchover off, backup
// - Charge-pump levels only in level mode above threshold
module pso_power_ctl
  import pso_pkg::*;
#(
  parameter int unsigned REFR_CYC = `PSO_US2CYC(`PSO_REFR_US),
  parameter int unsigned DEB_SHORT_CYC = `PSO_US2CYC(`PSO_DEB_SHORT_US),
  parameter int unsigned DEB_LONG_CYC = `PSO_US2CYC(`PSO_DEB_LONG_US),
  parameter int unsigned ARM_DSM_CYC = `PSO_US2CYC(`PSO_ARM_DSM_US),
  parameter int unsigned ARM_LSM_CYC = `PSO_US2CYC(`PSO_ARM_LSM_US)
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Nonvolatile configuration image
  input wire logic [5:0] i_nvm_image,
  input wire logic i_nvm_valid,
  // Asynchronous comparator levels
  input wire logic i_main_below_backup,
  input wire logic i_main_above_thresh,
  input wire logic i_backup_above_thresh,
  input wire logic i_main_present,
  input wire logic i_low_voltage_flag,
  // Event sources
  input wire logic i_ext_event_pin,
  input wire logic [7:0] i_clk_irq_src,
  // Outputs
  output logic o_irq_n,
  output logic o_use_backup,
  output logic o_host_port_en,
  output logic o_host_port_reset,
  output logic o_ext_event,
  output logic o_clkout_force_low,
  output logic o_clkout_auto_en,
  output logic o_temp_run,
  output logic o_charger_en,
  output logic o_charger_pump_ok,
  output logic [1:0] o_charger_mode_sel,
  output logic [1:0] o_charger_resistor_sel
);

  localparam int unsigned CNT_W = $clog2(DEB_LONG_CYC + 1);

  // Zero-length waits would skip refresh or debounce entirely
  if (REFR_CYC < 1 || DEB_SHORT_CYC < 1 || ARM_DSM_CYC < 1 || ARM_LSM_CYC < 1)
  begin : g_bad_zero
    $error("pso_power_ctl: timing counts must be at least one cycle");
  end
  // The shared counter is sized by the long debounce, so it must be the longest
  if (DEB_LONG_CYC < DEB_SHORT_CYC || DEB_LONG_CYC < REFR_CYC ||
      DEB_LONG_CYC < ARM_LSM_CYC || DEB_LONG_CYC < ARM_DSM_CYC)
  begin : g_bad_order
    $error("pso_power_ctl: long debounce must be the longest timing count");
  end

  // Two-stage synchronisers for pin-side levels
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  wire [5:0] async_in = {i_ext_event_pin, i_low_voltage_flag, i_main_present,
                         i_backup_above_thresh, i_main_above_thresh, i_main_below_backup};
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end
    else
    begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end
  wire main_below_bk = sync2_r[0];
  wire main_above_th = sync2_r[1];
  wire bk_above_th = sync2_r[2];
  wire main_present = sync2_r[3];
  wire low_voltage_flag = sync2_r[4];
  wire ext_event_s = sync2_r[5];

  // Registers
  pso_state_t state_r;
  pso_state_t state_nxt;
  logic [1:0] ctrl_r;
  logic [5:0] nvm_r;
  logic [7:0] clk_mask_r;
  logic power_loss_flag_r;
  logic switched_to_backup_flag_r;
  logic clkf_r;
  logic armed_r;
  logic boot_main_r;
  logic por_irq_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] arm_cnt_r;
  logic [31:0] prdata_r;

  // Decoding of the mirrored configuration
  wire pso_mode_t switchover_mode_sel = pso_mode_t'(nvm_r[`PSO_NVM_MODE_HI:`PSO_NVM_MODE_LO]);
  wire [1:0] charger_mode_sel = nvm_r[`PSO_NVM_TCM_HI:`PSO_NVM_TCM_LO];
  wire direct_switching = (switchover_mode_sel == PSO_MODE_DIRECT);
  wire level_switching = (switchover_mode_sel == PSO_MODE_LEVEL);
  wire sw_enabled = (direct_switching || level_switching) && boot_main_r;
  wire backup_irq_enable = ctrl_r[`PSO_CTRL_BACKUP_IRQ_ENABLE];
  wire power_loss_irq_enable = ctrl_r[`PSO_CTRL_POWER_LOSS_IRQ_ENABLE];

  // Supply choice; level mode falls back to direct when main and backup are both below threshold
  wire want_direct = main_below_bk;
  wire want_level = main_above_th ? 1'b0 : (bk_above_th ? 1'b1 : main_below_bk);
  wire want_backup = sw_enabled && armed_r && (level_switching ? want_level : want_direct);

  // APB decode; zero-wait answers
  wire apb_acc = i_psel && i_penable;
  wire apb_wr = apb_acc && i_pwrite;
  wire hit_ctrl = (i_paddr == `PSO_ADDR_CTRL);
  wire hit_stat = (i_paddr == `PSO_ADDR_STAT);
  wire hit_nvm = (i_paddr == `PSO_ADDR_NVM);
  wire hit_mask = (i_paddr == `PSO_ADDR_CLKMASK);
  wire hit_any = hit_ctrl || hit_stat || hit_nvm || hit_mask;
  // Host port is dead outside the main state, so software sees an error
  wire port_live = (state_r == PSO_ST_MAIN);
  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc && (!hit_any || !port_live);
  wire wr_ok = apb_wr && hit_any && port_live;
  wire clr_power_loss_flag = wr_ok && hit_stat && !i_pwdata[`PSO_STAT_POWER_LOSS_FLAG];
  wire clr_bsf = wr_ok && hit_stat && !i_pwdata[`PSO_STAT_BSF];

  wire [31:0] stat_word = {24'h000000, (state_r == PSO_ST_DEBOUNCE), armed_r, clkf_r,
                           (state_r == PSO_ST_REFRESH), (state_r == PSO_ST_BACKUP),
                           low_voltage_flag, switched_to_backup_flag_r, power_loss_flag_r};
  wire [31:0] rd_mux = hit_ctrl ? {30'h00000000, ctrl_r} :
                       hit_stat ? stat_word :
                       hit_nvm ? {26'h0000000, nvm_r} :
                       hit_mask ? {24'h000000, clk_mask_r} : 32'h00000000;

  // Counter expiry
  wire [CNT_W-1:0] deb_len = low_voltage_flag ? CNT_W'(DEB_LONG_CYC - 1) : CNT_W'(DEB_SHORT_CYC - 1);
  wire [CNT_W-1:0] arm_len = level_switching ? CNT_W'(ARM_LSM_CYC - 1) : CNT_W'(ARM_DSM_CYC - 1);
  wire refr_done = (cnt_r >= CNT_W'(REFR_CYC - 1)) && i_nvm_valid;
  wire deb_done = (cnt_r >= deb_len);

  // Power-state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PSO_ST_REFRESH: if (refr_done) state_nxt = PSO_ST_MAIN;
      PSO_ST_MAIN: if (want_backup) state_nxt = PSO_ST_BACKUP;
      PSO_ST_BACKUP: if (!want_backup) state_nxt = PSO_ST_DEBOUNCE;
      PSO_ST_DEBOUNCE:
      begin
        if (want_backup)
          state_nxt = PSO_ST_BACKUP;
        else if (deb_done)
          state_nxt = PSO_ST_MAIN;
      end
      default: state_nxt = PSO_ST_REFRESH;
    endcase
  end
  wire enter_backup = (state_nxt == PSO_ST_BACKUP) && (state_r != PSO_ST_BACKUP);

  // State and shared counter
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_r <= PSO_ST_REFRESH;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r) ? '0 : (cnt_r + CNT_W'(1));
    end
  end

  // Switchover arming delay after leaving a disabled mode
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      armed_r <= 1'b0;
      arm_cnt_r <= '0;
    end
    else if (!sw_enabled)
    begin
      armed_r <= 1'b0;
      arm_cnt_r <= '0;
    end
    else if (!armed_r)
    begin
      armed_r <= (arm_cnt_r >= arm_len);
      arm_cnt_r <= arm_cnt_r + CNT_W'(1);
    end
  end

  // Boot-supply strap caught at end of refresh, not under reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      boot_main_r <= 1'b0;
    else if (state_r == PSO_ST_REFRESH && refr_done)
      boot_main_r <= main_present;
  end

  // Configuration and mirror registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_r <= `PSO_CTRL_RST;
      nvm_r <= `PSO_NVM_RST;
      clk_mask_r <= `PSO_MASK_RST;
    end
    else
    begin
      if (state_r == PSO_ST_REFRESH && refr_done)
        nvm_r <= i_nvm_image;
      else if (wr_ok && hit_nvm)
        nvm_r <= i_pwdata[`PSO_NVM_W-1:0];
      if (wr_ok && hit_ctrl)
        ctrl_r <= i_pwdata[1:0];
      if (wr_ok && hit_mask)
        clk_mask_r <= i_pwdata[7:0];
    end
  end

  // Sticky flags; a set beats a same-cycle clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      power_loss_flag_r <= 1'b1;
      por_irq_r <= 1'b1;
      switched_to_backup_flag_r <= 1'b0;
      clkf_r <= 1'b0;
    end
    else
    begin
      if (clr_power_loss_flag)
      begin
        power_loss_flag_r <= 1'b0;
        por_irq_r <= 1'b0;
      end
      if (!sw_enabled)
        switched_to_backup_flag_r <= 1'b0;
      else if (enter_backup)
        switched_to_backup_flag_r <= 1'b1;
      else if (clr_bsf)
        switched_to_backup_flag_r <= 1'b0;
      if (state_r == PSO_ST_BACKUP && |(i_clk_irq_src & clk_mask_r))
        clkf_r <= 1'b1;
      else if (wr_ok && hit_stat && !i_pwdata[`PSO_STAT_CLKF])
        clkf_r <= 1'b0;
    end
  end

  // Read data register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      prdata_r <= 32'h00000000;
    else if (i_psel && !i_penable && !i_pwrite)
      prdata_r <= rd_mux;
  end
  assign o_prdata = prdata_r;

  // Pin-level outputs
  wire in_backup = (state_r == PSO_ST_BACKUP);
  assign o_irq_n = !((power_loss_irq_enable && por_irq_r) ||
                     (backup_irq_enable && switched_to_backup_flag_r));
  assign o_use_backup = in_backup || (state_r == PSO_ST_DEBOUNCE && want_backup);
  assign o_host_port_en = port_live;
  assign o_host_port_reset = !port_live;
  assign o_ext_event = ext_event_s && !in_backup;
  assign o_clkout_force_low = in_backup;
  assign o_clkout_auto_en = clkf_r && !in_backup;
  assign o_temp_run = 1'b1;
  assign o_charger_en = (charger_mode_sel != 2'h0) && sw_enabled && !in_backup;
  assign o_charger_pump_ok = o_charger_en && level_switching && main_above_th;
  assign o_charger_mode_sel = charger_mode_sel;
  assign o_charger_resistor_sel = nvm_r[`PSO_NVM_TCR_HI:`PSO_NVM_TCR_LO];

  // Checks
  chk_bsf_zero_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !sw_enabled |=> !switched_to_backup_flag_r) else $error("backup flag set while switchover off");
  chk_bsf_on_entry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    enter_backup && sw_enabled |=> switched_to_backup_flag_r) else $error("backup flag missed");
  chk_backup_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    backup_irq_enable && switched_to_backup_flag_r |-> !o_irq_n) else $error("backup irq missing");
  chk_clkout_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_backup |-> o_clkout_force_low && !o_ext_event) else $error("clock out not low in backup");
  chk_port_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(in_backup) |-> !o_host_port_en && o_host_port_reset) else $error("host port live in backup");
  chk_debounce_min: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(in_backup) && !want_backup |-> !o_host_port_en [*2]) else $error("debounce too short");
  chk_charger_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (charger_mode_sel == 2'h0 || !sw_enabled || in_backup) |-> !o_charger_en) else $error("charger on");
  chk_power_loss_flag_set: assert property (@(posedge i_clk)
    !i_rst_n |=> power_loss_flag_r) else $error("power-loss flag not set by reset");
  chk_por_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    power_loss_irq_enable && power_loss_flag_r |-> !o_irq_n) else $error("power-loss irq missing");
  chk_por_irq_rearm: assert property (@(posedge i_clk)
    !i_rst_n |=> por_irq_r) else $error("power-loss interrupt not re-armed by reset");
  chk_pump_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_charger_pump_ok |-> level_switching && main_above_th) else $error("pump level wrongly enabled");

  // Refresh, boot strap and arming
  chk_refresh_closed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == PSO_ST_REFRESH |-> !o_host_port_en && !wr_ok) else $error("host port live during refresh");
  chk_refresh_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == PSO_ST_REFRESH && refr_done |=> nvm_r == $past(i_nvm_image)) else $error("mirror not loaded");
  chk_boot_backup: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !boot_main_r |-> !o_use_backup && !o_charger_en) else $error("switchover active after backup boot");
  chk_arm_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sw_enabled && !armed_r |-> arm_cnt_r <= CNT_W'(ARM_LSM_CYC)) else $error("switchover arming overran");
  chk_arm_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !sw_enabled |=> !armed_r) else $error("armed while switchover off");

  // Mode decode and supply choice
  chk_mode_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !sw_enabled |=> !o_use_backup) else $error("backup used while switchover off");
  chk_level_pick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    port_live && level_switching && main_above_th |=> !in_backup) else $error("level mode left main supply");

  // Port, event and clock-output paths
  chk_event_pass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !in_backup |-> o_ext_event == ext_event_s) else $error("event input blocked outside backup");
  chk_port_error: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    apb_acc && !port_live |-> o_pslverr) else $error("access to dead host port not refused");
  chk_clkf_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_backup && |(i_clk_irq_src & clk_mask_r) |=> clkf_r) else $error("clock interrupt lost in backup");

  cov_backup: cover property (@(posedge i_clk) disable iff (!i_rst_n) enter_backup);
  cov_return: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == PSO_ST_DEBOUNCE ##1 state_r == PSO_ST_MAIN);
  cov_refresh: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == PSO_ST_REFRESH ##1 state_r == PSO_ST_MAIN);
  cov_clkf: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(clkf_r));
  cov_level_backup: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    enter_backup && level_switching);

endmodule // pso_power_ctl

// [testbench/pso_supply_model.sv]
`timescale 1ns/10ps
// Supply comparators facing the block: millivolts in, digital levels out
module pso_supply_model #(
  parameter int unsigned TH_MV = 2000,
  parameter int unsigned MIN_MV = 1400
)
(
  input wire logic [11:0] i_vdd_mv,
  input wire logic [11:0] i_vbak_mv,
  output logic o_main_below_backup,
  output logic o_main_above_thresh,
  output logic o_backup_above_thresh,
  output logic o_main_present
);
  // Ideal comparators; no hysteresis, so the block's own filtering is exposed
  assign o_main_below_backup = i_vdd_mv < i_vbak_mv;
  assign o_main_above_thresh = i_vdd_mv > TH_MV;
  assign o_backup_above_thresh = i_vbak_mv > TH_MV;
  assign o_main_present = i_vdd_mv >= MIN_MV;
endmodule // pso_supply_model

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`include "pso_defs.svh"
module tb_top
  import pso_pkg::*;
;
  localparam int TH = 2000;
  localparam int DEB_S = 10;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_nvm_valid, i_low_voltage_flag, i_ext_event_pin;
  logic [11:0] i_paddr, vdd_mv, vbak_mv;
  logic [31:0] i_pwdata, o_prdata, rd, seed;
  logic [5:0] i_nvm_image, img;
  logic [7:0] i_clk_irq_src;
  logic o_pready, o_pslverr, o_irq_n, o_use_backup, o_host_port_en, o_host_port_reset, o_ext_event;
  logic o_clkout_force_low, o_clkout_auto_en, o_temp_run, o_charger_en, o_charger_pump_ok, err, bk;
  logic mbb, mat, bat, mpres;
  int error_cnt;
  int samples_checked;

  // Free-running 100 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Short counts keep the run brief; expectations use the same figures
  pso_power_ctl #(.REFR_CYC(20), .DEB_SHORT_CYC(DEB_S), .DEB_LONG_CYC(40), .ARM_DSM_CYC(5), .ARM_LSM_CYC(15))
  pso_power_ctl_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_nvm_image(i_nvm_image), .i_nvm_valid(i_nvm_valid), .i_main_below_backup(mbb),
    .i_main_above_thresh(mat), .i_backup_above_thresh(bat), .i_main_present(mpres),
    .i_low_voltage_flag(i_low_voltage_flag), .i_ext_event_pin(i_ext_event_pin), .i_clk_irq_src(i_clk_irq_src),
    .o_irq_n(o_irq_n), .o_use_backup(o_use_backup), .o_host_port_en(o_host_port_en),
    .o_host_port_reset(o_host_port_reset), .o_ext_event(o_ext_event), .o_clkout_force_low(o_clkout_force_low),
    .o_clkout_auto_en(o_clkout_auto_en), .o_temp_run(o_temp_run), .o_charger_en(o_charger_en),
    .o_charger_pump_ok(o_charger_pump_ok), .o_charger_mode_sel(), .o_charger_resistor_sel());

  pso_supply_model #(.TH_MV(TH)) pso_supply_model_i (.i_vdd_mv(vdd_mv), .i_vbak_mv(vbak_mv),
    .o_main_below_backup(mbb), .o_main_above_thresh(mat), .o_backup_above_thresh(bat), .o_main_present(mpres));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Supply the block should pick for a mode and a pair of voltages
  function automatic logic exp_bk(input logic [1:0] m, input logic [11:0] vd, input logic [11:0] vb);
    if (m == PSO_MODE_DIRECT) return vd < vb;
    if (m == PSO_MODE_LEVEL) return !(vd > TH) && ((vb > TH) || (vd < vb));
    return 1'b0;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial
  begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    seed = 32'h1011;
    i_rst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    i_nvm_image = 6'h25;
    i_nvm_valid = 1'b1;
    i_low_voltage_flag = 1'b0;
    i_ext_event_pin = 1'b1;
    i_clk_irq_src = 8'h00;
    vdd_mv = 12'hCE4;
    vbak_mv = 12'hBB8;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    // Port stays closed while the image is copied in
    apb(1'b0, `PSO_ADDR_STAT, 32'h0);
    chk(err, 1'b1);
    repeat (30) @(posedge i_clk);
    apb(1'b0, `PSO_ADDR_STAT, 32'h0);
    chk(rd[`PSO_STAT_POWER_LOSS_FLAG], 1'b1);
    apb(1'b0, `PSO_ADDR_NVM, 32'h0);
    chk(rd, 32'h25);
    apb(1'b0, `PSO_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `PSO_ADDR_CLKMASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, `PSO_ADDR_CTRL, 32'h2);
    @(posedge i_clk);
    chk(o_irq_n, 1'b0);
    apb(1'b1, `PSO_ADDR_STAT, 32'h1);
    apb(1'b0, `PSO_ADDR_STAT, 32'h0);
    chk(rd[`PSO_STAT_POWER_LOSS_FLAG], 1'b1);
    apb(1'b1, `PSO_ADDR_STAT, 32'h0);
    apb(1'b0, `PSO_ADDR_STAT, 32'h0);
    chk(rd[`PSO_STAT_POWER_LOSS_FLAG], 1'b0);
    chk(o_irq_n, 1'b1);
    // Direct-mode dip with only the backup interrupt enabled and clock interrupt bit 0 unmasked, twice: short then long debounce
    apb(1'b1, `PSO_ADDR_CTRL, 32'h1);
    apb(1'b1, `PSO_ADDR_CLKMASK, 32'h1);
    for (int n = 0; n < 2; n++)
    begin
      i_low_voltage_flag <= n[0];
      repeat (20) @(posedge i_clk);
      vdd_mv <= 12'h9C4;
      repeat (10) @(posedge i_clk);
      chk(o_use_backup, 1'b1);
      chk(o_irq_n, 1'b0);
      chk({o_host_port_en, o_host_port_reset}, 2'b01);
      chk(o_ext_event, 1'b0);
      chk(o_clkout_force_low, 1'b1);
      chk(o_charger_en, 1'b0);
      chk(o_temp_run, 1'b1);
      i_clk_irq_src <= 8'h01;
      @(posedge i_clk);
      i_clk_irq_src <= 8'h00;
      vdd_mv <= 12'hCE4;
      // Two synchroniser stages and the state step come before the debounce count
      repeat (DEB_S + 4) @(posedge i_clk);
      chk(o_host_port_en, n[0]? 1'b0 : 1'b1);
      repeat (40) @(posedge i_clk);
      chk(o_host_port_en, 1'b1);
      chk(o_clkout_auto_en, 1'b1);
      chk(o_ext_event, 1'b1);
      apb(1'b0, `PSO_ADDR_STAT, 32'h0);
      chk(rd[`PSO_STAT_BSF], 1'b1);
      apb(1'b1, `PSO_ADDR_STAT, 32'h0);
      @(posedge i_clk);
      chk(o_irq_n, 1'b1);
    end
    i_low_voltage_flag <= 1'b0;
    // Every mode with random supplies and charger setting
    for (int i = 0; i < 16; i++)
    begin
      vdd_mv <= 12'hCE4;
      vbak_mv <= 12'h3E8;
      repeat (60) @(posedge i_clk);
      img = 6'(xs());
      img[1:0] = i[1:0];
      apb(1'b1, `PSO_ADDR_NVM, {26'h0, img});
      repeat (30) @(posedge i_clk);
      vdd_mv <= 12'(12'h5DC + (xs() % 2000));
      vbak_mv <= 12'(12'h5DC + (xs() % 2000));
      repeat (20) @(posedge i_clk);
      bk = exp_bk(img[1:0], vdd_mv, vbak_mv);
      chk(o_use_backup, bk);
      chk(o_charger_en, (img[3:2] != 2'h0) && (img[1] != img[0]) && !bk);
      chk(o_charger_pump_ok, (img[3:2] != 2'h0) && (img[1:0] == 2'h2) && (vdd_mv > TH));
      if (img[1] == img[0])
      begin
        apb(1'b0, `PSO_ADDR_STAT, 32'h0);
        chk(rd[`PSO_STAT_BSF], 1'b0);
      end
    end
    // Second power-on reset: flag returns with no software help, interrupt once the enable is written again
    vdd_mv <= 12'hCE4;
    vbak_mv <= 12'h3E8;
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (30) @(posedge i_clk);
    apb(1'b0, `PSO_ADDR_STAT, 32'h0);
    chk(rd[`PSO_STAT_POWER_LOSS_FLAG], 1'b1);
    apb(1'b1, `PSO_ADDR_CTRL, 32'h2);
    @(posedge i_clk);
    chk(o_irq_n, 1'b0);
    complete_run();
  end
endmodule // tb_top
